// file: inc/ssp_defines.vh
/*
  Register indices, field positions and reset values of the 8-bit clocked
  serial shift port. Assumes a 32-bit APB slave in which every register
  takes one aligned word at byte address four times its index.
*/
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// register indices; byte address is index * 4
`define SSP_IDX_PULLUP      16'hFF45
`define SSP_IDX_ENTRIG      16'hFF70
`define SSP_IDX_CONFIG      16'hFF71
`define SSP_IDX_DATA_LO     16'hFF72
`define SSP_IDX_DATA_HI     16'hFF73
`define SSP_IDX_IRQ         16'hFF74

// port1_pullup_control fields
`define SSP_PUL_IN_BIT      0
`define SSP_PUL_CLK_BIT     2
`define SSP_PUL_IN_RST      1'b1
`define SSP_PUL_CLK_RST     1'b1

// serial_enable_trigger fields
`define SSP_EN_FUNC_BIT     0
`define SSP_EN_TRIG_BIT     1
`define SSP_EN_FUNC_RST     1'b0

// serial_clock_order_config fields
`define SSP_CFG_SRC_LO_BIT  0
`define SSP_CFG_SRC_HI_BIT  1
`define SSP_CFG_PHASE_BIT   2
`define SSP_CFG_ORDER_BIT   3
`define SSP_CFG_SRC_RST     2'h0
`define SSP_CFG_PHASE_RST   1'b0
`define SSP_CFG_ORDER_RST   1'b0

// interrupt flag / mask register fields
`define SSP_IRQ_FLAG_BIT    0
`define SSP_IRQ_MASK_BIT    1
`define SSP_IRQ_MASK_RST    1'b0

// clock source encodings
`define SSP_SRC_SLAVE       2'h0
`define SSP_SRC_TIMER       2'h1
`define SSP_SRC_OSC_HALF    2'h2
`define SSP_SRC_OSC         2'h3

// transfer length
`define SSP_LAST_BIT        3'h7

`endif

// file: hw/ssp_clkgen.v
/*
  Master shift clock event source: one tick per half period of the shift
  clock, taken from the oscillator edge pulses, their half, or the timer
  underflow pulses. Assumes source pulses are one clk_sys_in cycle wide.
*/
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_clkgen
(
  input  wire       clk_sys_in,
  input  wire       resetn_in,
  input  wire       ce_in,
  input  wire [1:0] source_sel_in,
  input  wire       osc_edge_in,
  input  wire       timer_underflow_in,
  output reg        tick_out
);

  reg half_div;

  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      half_div <= 1'b0;
      tick_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (osc_edge_in)
        half_div <= ~half_div;
      case (source_sel_in)
        `SSP_SRC_OSC:      tick_out <= osc_edge_in;
        `SSP_SRC_OSC_HALF: tick_out <= osc_edge_in & half_div;
        // each underflow toggles the clock: rate is underflow / 2
        `SSP_SRC_TIMER:    tick_out <= timer_underflow_in;
        default:           tick_out <= 1'b0;
      endcase
    end
  end

endmodule

// file: hw/ssp_edge.v
/*
  Edge finder for a level already synchronous to clk_sys_in. Gives one
  cycle pulses on the rise and the fall of the level.
*/
`timescale 1ns/1ps

module ssp_edge
(
  input  wire clk_sys_in,
  input  wire resetn_in,
  input  wire ce_in,
  input  wire level_in,
  output wire rise_out,
  output wire fall_out
);

  reg prev;

  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      prev <= 1'b0;
    else if (ce_in)
      prev <= level_in;
  end

  assign rise_out = ce_in & level_in & ~prev;
  assign fall_out = ce_in & ~level_in & prev;

endmodule

// file: hw/ssp_top.v
/*
  8-bit clocked serial shift port with APB register access, master clock
  generation, slave ready output and shared pin multiplexing.
  Assumes APB signals, oscillator edge pulses, timer underflow pulses and
  pin inputs are all synchronous to clk_sys_in.
*/
// Summary of operation
// - trigger sends loaded byte on serial out
// - master drives clock pin; slave takes it
// - negative polarity: out bit changes on falling edge
// - negative polarity: sample falling if phase 1, else rising
// - positive polarity: out bit changes on rising edge
// - positive polarity: sample rising if phase 1, else falling
// - eighth bit sets done flag, requests interrupt
// - mask gates request only; flag always sets
// - received byte readable in data nibbles
// - bit order applies to both directions
// - slave mode drives ready output
// - ready idles inactive: high negative, low positive
// - ready on at trigger, off at first active level
// - high nibble access drops ready
// - function bit 1 gives pins to port; resets 0
// - fourth pin: ready as slave, I/O as master
// - pull-up bits: 1 on; reset 1
// - clock pull-up acts unless master with function bit 1
// - source: 11 osc, 10 osc half, 01 timer, 00 slave
// - timer clock is underflow divided by two
// - source resets to slave
// - master parks clock after eight; slave ignores extras
// - trigger reads 1 until eight counts; 0 after reset
// - bit order 1 msb first; resets 0
`timescale 1ns/1ps
`include "ssp_defines.vh"

module ssp_top
#(
  parameter       POSITIVE_POLARITY = 0,
  parameter       ADDR_W            = 18
)
(
  input  wire              clk_sys_in,
  input  wire              resetn_in,
  input  wire              ce_in,
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [ADDR_W-1:0] paddr_in,
  input  wire [31:0]       pwdata_in,
  input  wire [3:0]        pstrb_in,
  output reg  [31:0]       prdata_out,
  output reg               pready_out,
  output reg               pslverr_out,
  input  wire              osc_edge_in,
  input  wire              timer_underflow_in,
  input  wire [3:0]        gpio_data_in,
  input  wire [3:0]        gpio_drive_in,
  input  wire [3:0]        shared_pin_in,
  output reg  [3:0]        shared_pin_out,
  output reg  [3:0]        shared_pin_oe_n_out,
  output reg               input_pullup_out,
  output reg               clock_pullup_out,
  output reg               transfer_irq_out
);

  localparam [0:0] ACT_LVL = (POSITIVE_POLARITY != 0) ? 1'b1 : 1'b0;
  localparam [1:0] SRC_RST = `SSP_CFG_SRC_RST;

  localparam [2:0] SEL_NONE   = 3'h0;
  localparam [2:0] SEL_PULLUP = 3'h1;
  localparam [2:0] SEL_ENTRIG = 3'h2;
  localparam [2:0] SEL_CONFIG = 3'h3;
  localparam [2:0] SEL_LO     = 3'h4;
  localparam [2:0] SEL_HI     = 3'h5;
  localparam [2:0] SEL_IRQ    = 3'h6;

  // registers
  reg        input_pullup_ctrl;
  reg        clock_pullup_ctrl;
  reg        port_function_select;
  reg        clock_source_hi;
  reg        clock_source_lo;
  reg        sample_phase_select;
  reg        bit_order_select;
  reg        transfer_done_flag;
  reg        transfer_irq_mask;
  reg [7:0]  shift_reg;
  reg        running;
  reg [2:0]  bit_count;
  reg        serial_out_bit;
  reg        master_act;
  reg        ready_act;

  // word address to register select
  function [2:0] ssp_decode;
    input [ADDR_W-1:0] addr;
    begin
      ssp_decode = SEL_NONE;
      if (addr[1:0] == 2'h0)
      begin
        case (addr[17:2])
          `SSP_IDX_PULLUP:  ssp_decode = SEL_PULLUP;
          `SSP_IDX_ENTRIG:  ssp_decode = SEL_ENTRIG;
          `SSP_IDX_CONFIG:  ssp_decode = SEL_CONFIG;
          `SSP_IDX_DATA_LO: ssp_decode = SEL_LO;
          `SSP_IDX_DATA_HI: ssp_decode = SEL_HI;
          `SSP_IDX_IRQ:     ssp_decode = SEL_IRQ;
          default:          ssp_decode = SEL_NONE;
        endcase
      end
    end
  endfunction

  // bit leaving the register next, by bit order
  function ssp_out_bit;
    input [7:0] sr;
    input       msb_first;
    begin
      ssp_out_bit = msb_first ? sr[7] : sr[0];
    end
  endfunction

  // shift in at the far end
  function [7:0] ssp_shift;
    input [7:0] sr;
    input       din;
    input       msb_first;
    begin
      if (msb_first)
        ssp_shift = {sr[6:0], din};
      else
        ssp_shift = {din, sr[7:1]};
    end
  endfunction

  wire [1:0] clock_source = {clock_source_hi, clock_source_lo};
  wire       slave_mode   = (clock_source == `SSP_SRC_SLAVE);

  // access ends where pready is seen high
  wire       access    = psel_in & penable_in & ~pready_out;
  wire       complete  = psel_in & penable_in & pready_out;
  wire [2:0] sel       = ssp_decode(paddr_in);
  wire       wr_done   = complete & pwrite_in & pstrb_in[0];
  wire       acc_hi    = complete & (sel == SEL_HI);
  wire       trig_wr   = wr_done & (sel == SEL_ENTRIG) &
                         pwdata_in[`SSP_EN_TRIG_BIT];

  // 1 means active level
  wire       master_tick;
  wire       slave_act = shared_pin_in[2] ^ ~ACT_LVL;
  wire       shift_act = slave_mode ? slave_act : master_act;
  wire       lead_edge;
  wire       trail_edge;
  wire       lead_ok   = lead_edge & running;
  wire       trail_ok  = trail_edge & running;
  wire       done      = trail_ok & (bit_count == `SSP_LAST_BIT);

  ssp_clkgen u_clkgen
  (
    .clk_sys_in         (clk_sys_in),
    .resetn_in          (resetn_in),
    .ce_in              (ce_in),
    .source_sel_in      (clock_source),
    .osc_edge_in        (osc_edge_in),
    .timer_underflow_in (timer_underflow_in),
    .tick_out           (master_tick)
  );

  ssp_edge u_edge
  (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .ce_in      (ce_in),
    .level_in   (shift_act),
    .rise_out   (lead_edge),
    .fall_out   (trail_edge)
  );

  // APB slave: one wait state, then pready with data
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end
    else if (ce_in)
    begin
      pready_out  <= access;
      pslverr_out <= access & (sel == SEL_NONE);
      prdata_out  <= 32'h00000000;
      if (access & ~pwrite_in)
      begin
        case (sel)
          SEL_PULLUP:
          begin
            prdata_out[`SSP_PUL_IN_BIT]  <= input_pullup_ctrl;
            prdata_out[`SSP_PUL_CLK_BIT] <= clock_pullup_ctrl;
          end
          SEL_ENTRIG:
          begin
            prdata_out[`SSP_EN_FUNC_BIT] <= port_function_select;
            prdata_out[`SSP_EN_TRIG_BIT] <= running;
          end
          SEL_CONFIG:
          begin
            prdata_out[`SSP_CFG_SRC_LO_BIT] <= clock_source_lo;
            prdata_out[`SSP_CFG_SRC_HI_BIT] <= clock_source_hi;
            prdata_out[`SSP_CFG_PHASE_BIT]  <= sample_phase_select;
            prdata_out[`SSP_CFG_ORDER_BIT]  <= bit_order_select;
          end
          SEL_LO:  prdata_out[3:0] <= shift_reg[3:0];
          SEL_HI:  prdata_out[3:0] <= shift_reg[7:4];
          SEL_IRQ:
          begin
            prdata_out[`SSP_IRQ_FLAG_BIT] <= transfer_done_flag;
            prdata_out[`SSP_IRQ_MASK_BIT] <= transfer_irq_mask;
          end
          default: prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // software-written control bits
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      input_pullup_ctrl    <= `SSP_PUL_IN_RST;
      clock_pullup_ctrl    <= `SSP_PUL_CLK_RST;
      port_function_select <= `SSP_EN_FUNC_RST;
      clock_source_hi      <= SRC_RST[1];
      clock_source_lo      <= SRC_RST[0];
      sample_phase_select  <= `SSP_CFG_PHASE_RST;
      bit_order_select     <= `SSP_CFG_ORDER_RST;
      transfer_irq_mask    <= `SSP_IRQ_MASK_RST;
    end
    else if (ce_in && wr_done)
    begin
      case (sel)
        SEL_PULLUP:
        begin
          input_pullup_ctrl <= pwdata_in[`SSP_PUL_IN_BIT];
          clock_pullup_ctrl <= pwdata_in[`SSP_PUL_CLK_BIT];
        end
        SEL_ENTRIG:
          port_function_select <= pwdata_in[`SSP_EN_FUNC_BIT];
        SEL_CONFIG:
        begin
          clock_source_lo     <= pwdata_in[`SSP_CFG_SRC_LO_BIT];
          clock_source_hi     <= pwdata_in[`SSP_CFG_SRC_HI_BIT];
          sample_phase_select <= pwdata_in[`SSP_CFG_PHASE_BIT];
          bit_order_select    <= pwdata_in[`SSP_CFG_ORDER_BIT];
        end
        SEL_IRQ:
          transfer_irq_mask <= pwdata_in[`SSP_IRQ_MASK_BIT];
        default:
          transfer_irq_mask <= transfer_irq_mask;
      endcase
    end
  end

  // transfer engine
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      shift_reg          <= 8'h00;
      running            <= 1'b0;
      bit_count          <= 3'h0;
      serial_out_bit     <= 1'b0;
      transfer_done_flag <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_done && sel == SEL_LO)
        shift_reg[3:0] <= pwdata_in[3:0];
      if (wr_done && sel == SEL_HI)
        shift_reg[7:4] <= pwdata_in[3:0];
      // a second trigger while running is ignored, not restarted
      if (trig_wr && !running)
      begin
        running   <= 1'b1;
        bit_count <= 3'h0;
      end
      else if (running)
      begin
        // output changes on the leading edge of each active level
        if (lead_ok)
          serial_out_bit <= ssp_out_bit(shift_reg, bit_order_select);
        // sample on the leading edge with phase 1, trailing with phase 0
        if ((lead_ok && sample_phase_select) ||
            (trail_ok && !sample_phase_select))
          shift_reg <= ssp_shift(shift_reg, shared_pin_in[0],
                                 bit_order_select);
        if (trail_ok)
          bit_count <= bit_count + 3'h1;
        if (done)
          running <= 1'b0;
      end
      // set beats a same-cycle clear
      if (done)
        transfer_done_flag <= 1'b1;
      else if (wr_done && sel == SEL_IRQ &&
               pwdata_in[`SSP_IRQ_FLAG_BIT])
        transfer_done_flag <= 1'b0;
    end
  end

  // master clock parks idle once stopped
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      master_act <= 1'b0;
    else if (ce_in)
    begin
      if (slave_mode || (!running && !master_act))
        master_act <= 1'b0;
      else if (master_tick)
        master_act <= ~master_act;
    end
  end

  // slave ready level
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ready_act <= 1'b0;
    else if (ce_in)
    begin
      if (acc_hi || lead_ok || !slave_mode)
        ready_act <= 1'b0;
      else if (trig_wr && !running)
        ready_act <= 1'b1;
    end
  end

  // pin multiplexing, registered
  always @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      shared_pin_out      <= 4'h0;
      shared_pin_oe_n_out <= 4'hF;
      input_pullup_out    <= `SSP_PUL_IN_RST;
      clock_pullup_out    <= `SSP_PUL_CLK_RST;
      transfer_irq_out    <= 1'b0;
    end
    else if (ce_in)
    begin
      shared_pin_out      <= gpio_data_in;
      shared_pin_oe_n_out <= ~gpio_drive_in;
      if (port_function_select)
      begin
        shared_pin_oe_n_out[0] <= 1'b1;
        shared_pin_out[1]      <= serial_out_bit;
        shared_pin_oe_n_out[1] <= 1'b0;
        // clock pin: driven as master, input as slave
        shared_pin_out[2]      <= master_act ^ ~ACT_LVL;
        shared_pin_oe_n_out[2] <= slave_mode;
        if (slave_mode)
        begin
          shared_pin_out[3]      <= ready_act ^ ~ACT_LVL;
          shared_pin_oe_n_out[3] <= 1'b0;
        end
      end
      input_pullup_out <= input_pullup_ctrl;
      // as master with function bit 1 the clock pull-up bit is only storage
      clock_pullup_out <= clock_pullup_ctrl &
                          ~(port_function_select & ~slave_mode);
      transfer_irq_out <= transfer_done_flag & transfer_irq_mask;
    end
  end

endmodule

// file: sim/ssp_checker.sv
/*
  Port assertions for the serial shift port top.
  Assumes negative clock polarity, steady gpio inputs, ce_in held high.
*/
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_checker
#(
  parameter ADDR_W = 18
)
(
  input wire              clk_sys_in,
  input wire              resetn_in,
  input wire              psel_in,
  input wire              penable_in,
  input wire              pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0]       pwdata_in,
  input wire [3:0]        pstrb_in,
  input wire              pready_out,
  input wire [3:0]        gpio_data_in,
  input wire [3:0]        gpio_drive_in,
  input wire [3:0]        shared_pin_out,
  input wire [3:0]        shared_pin_oe_n_out,
  input wire              input_pullup_out,
  input wire              clock_pullup_out,
  input wire              transfer_irq_out
);
  localparam [ADDR_W-1:0] A_EN  = {`SSP_IDX_ENTRIG, 2'h0};
  localparam [ADDR_W-1:0] A_CFG = {`SSP_IDX_CONFIG, 2'h0};
  localparam [ADDR_W-1:0] A_HI  = {`SSP_IDX_DATA_HI, 2'h0};
  localparam [ADDR_W-1:0] A_IRQ = {`SSP_IDX_IRQ, 2'h0};
  reg       func_r;
  reg       mask_r;
  reg       run_r;
  reg [1:0] src_r;
  reg [3:0] cnt;
  wire      wr  = psel_in & penable_in & pready_out & pwrite_in & pstrb_in[0];
  wire      mst = func_r & (src_r != 2'h0);
  wire      slv = func_r & (src_r == 2'h0);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // shadow of software state, so pin rules can be judged
  always @(posedge clk_sys_in or negedge resetn_in)
    if (!resetn_in)
    begin
      func_r <= 1'h0;
      src_r  <= 2'h0;
      mask_r <= 1'h0;
      run_r  <= 1'h0;
      cnt    <= 4'h0;
    end
    else
    begin
      if (wr && paddr_in == A_EN) func_r <= pwdata_in[0];
      if (wr && paddr_in == A_CFG) src_r <= pwdata_in[1:0];
      if (wr && paddr_in == A_IRQ) mask_r <= pwdata_in[1];
      if (wr && paddr_in == A_EN && pwdata_in[1] && mst && !run_r)
      begin
        run_r <= 1'h1;
        cnt   <= 4'h0;
      end
      else if (mst && $rose(shared_pin_out[2]))
      begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h7) run_r <= 1'h0;
      end
    end
  sequence s_acc;
    psel_in && penable_in && pready_out;
  endsequence
  sequence s_wait;
    psel_in && !penable_in ##1 psel_in && penable_in && !pready_out;
  endsequence
  property p_wait; s_wait |=> pready_out; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_one; pready_out |=> !pready_out; endproperty
  a_one: assert property (p_one) else $error("pready too long");
  property p_pull_rst;
    $rose(resetn_in) |-> input_pullup_out && clock_pullup_out;
  endproperty
  a_pull_rst: assert property (p_pull_rst) else $error("pullup reset");
  property p_irq; transfer_irq_out |-> mask_r || $past(mask_r); endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
  property p_gpio;
    (!func_r)[*3] |-> shared_pin_oe_n_out == ~$past(gpio_drive_in)
      && shared_pin_out == $past(gpio_data_in);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio pin mux");
  property p_mclk;
    mst[*2] |-> !shared_pin_oe_n_out[2]
      && shared_pin_oe_n_out[3] == !$past(gpio_drive_in[3]);
  endproperty
  a_mclk: assert property (p_mclk) else $error("master pins");
  property p_sclk;
    slv[*2] |-> shared_pin_oe_n_out[2] && !shared_pin_oe_n_out[3];
  endproperty
  a_sclk: assert property (p_sclk) else $error("slave pins");
  property p_cpu; (src_r != 2'h0)[*2] |-> !clock_pullup_out; endproperty
  a_cpu: assert property (p_cpu) else $error("clock pullup");
  property p_rdy_on;
    s_acc ##0 (pwrite_in && paddr_in == A_EN && pwdata_in[1] && slv)
      |-> ##[1:3] !shared_pin_out[3];
  endproperty
  a_rdy_on: assert property (p_rdy_on) else $error("ready on");
  property p_rdy_off;
    s_acc ##0 (paddr_in == A_HI && slv) |-> ##[1:3] shared_pin_out[3];
  endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready off");
  property p_count; cnt <= 4'h8; endproperty
  a_count: assert property (p_count) else $error("extra pulses");
  property p_park;
    run_r && cnt == 4'h7 && $rose(shared_pin_out[2])
      |=> shared_pin_out[2][*8];
  endproperty
  a_park: assert property (p_park) else $error("clock not parked");
  property p_serial_out_pin;
    run_r && $changed(shared_pin_out[1])
      |-> $past(shared_pin_out[2], 2) && !$past(shared_pin_out[2]);
  endproperty
  a_serial_out_pin: assert property (p_serial_out_pin) else $error("serial_out_pin edge");
endmodule

bind ssp_top ssp_checker #(.ADDR_W(ADDR_W)) ssp_checker_inst
(
  .clk_sys_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pstrb_in, .pready_out, .gpio_data_in, .gpio_drive_in,
  .shared_pin_out, .shared_pin_oe_n_out, .input_pullup_out,
  .clock_pullup_out, .transfer_irq_out
);

// file: sim/ssp_partner.sv
/*
  Far-side serial device: shifts a byte onto serial in, captures serial
  out, and as external master makes clock pulses. Assumes negative polarity.
*/
`timescale 1ns/1ps
module ssp_partner
(
  input  wire       clk_in,
  input  wire       pin_clk_in,
  input  wire       serial_out_pin_in,
  input  wire       msb_in,
  input  wire       phase_in,
  input  wire       load_in,
  input  wire       gen_in,
  input  wire [7:0] tx_in,
  input  wire [3:0] pulses_in,
  output reg        sin_out,
  output reg        clk_out,
  output reg  [7:0] rx_out
);
  reg       p = 1'h1;
  reg [3:0] n = 4'h8;
  reg [3:0] m = 4'h8;
  reg [3:0] g = 4'h0;
  reg [4:0] h = 5'h0;
  initial sin_out = 1'h1;
  initial clk_out = 1'h1;
  initial rx_out = 8'h0;
  // pull-up past bit eight
  function bitn(input [3:0] k);
    bitn = (k > 4'h7) ? 1'h1 : (msb_in ? tx_in[3'h7 - k[2:0]] : tx_in[k[2:0]]);
  endfunction
  always @(posedge clk_in)
  begin
    p <= pin_clk_in;
    if (load_in)
    begin
      n <= 4'h0;
      m <= 4'h0;
      sin_out <= bitn(4'h0);
    end
    else
    begin
      // data leads the fetch edge
      if (phase_in && !p && pin_clk_in)
      begin
        n <= n + 4'h1;
        sin_out <= bitn(n + 4'h1);
      end
      if (!phase_in && p && !pin_clk_in)
      begin
        n <= n + 4'h1;
        sin_out <= bitn(n);
      end
      if (!p && pin_clk_in && m < 4'h8)
      begin
        m <= m + 4'h1;
        rx_out <= msb_in ? {rx_out[6:0], serial_out_pin_in} : {serial_out_pin_in, rx_out[7:1]};
      end
    end
    // 20 cycles a half: 1 MHz
    if (gen_in)
    begin
      g <= pulses_in;
      h <= 5'h0;
    end
    else if (g != 4'h0)
    begin
      h <= (h == 5'h13) ? 5'h0 : h + 5'h1;
      if (h == 5'h13) clk_out <= !clk_out;
      if (h == 5'h13 && !clk_out) g <= g - 4'h1;
    end
  end
endmodule

// file: sim/testbench.sv
/*
  Self-checking bench for the serial shift port top with APB register
  access, a far-side partner and resolved shared pins.
*/
`timescale 1ns/1ps
`include "ssp_defines.vh"
module testbench;
  localparam [17:0] A_PUL = {`SSP_IDX_PULLUP, 2'h0};
  localparam [17:0] A_EN  = {`SSP_IDX_ENTRIG, 2'h0};
  localparam [17:0] A_CFG = {`SSP_IDX_CONFIG, 2'h0};
  localparam [17:0] A_LO  = {`SSP_IDX_DATA_LO, 2'h0};
  localparam [17:0] A_HI  = {`SSP_IDX_DATA_HI, 2'h0};
  localparam [17:0] A_IRQ = {`SSP_IDX_IRQ, 2'h0};
  reg         clk_sys;
  reg         resetn;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [17:0] paddr;
  reg  [31:0] pwdata;
  reg         osc_edge;
  reg         tmr_uf;
  reg         pmsb;
  reg         pph;
  reg         pload;
  reg         pgen;
  reg  [7:0]  ptx;
  reg  [3:0]  npulse;
  reg  [31:0] q;
  reg         e;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        in_pu;
  wire        clk_pu;
  wire        irq;
  wire [3:0]  pin_out;
  wire [3:0]  pin_oe_n;
  wire [3:0]  pin;
  wire        psin;
  wire        pclk;
  wire [7:0]  prx;
  integer     mismatches;
  integer     compares;
  integer     cyc;
  assign pin = (pin_oe_n & {1'h1, pclk, 1'h1, psin}) | (~pin_oe_n & pin_out);
  ssp_top ssp_top_inst
  (
    .clk_sys_in(clk_sys), .resetn_in(resetn), .ce_in(1'h1), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .osc_edge_in(osc_edge),
    .timer_underflow_in(tmr_uf), .gpio_data_in(4'hD), .gpio_drive_in(4'h9),
    .shared_pin_in(pin), .shared_pin_out(pin_out),
    .shared_pin_oe_n_out(pin_oe_n), .input_pullup_out(in_pu),
    .clock_pullup_out(clk_pu), .transfer_irq_out(irq)
  );
  ssp_partner ssp_partner_inst
  (
    .clk_in(clk_sys), .pin_clk_in(pin[2]), .serial_out_pin_in(pin[1]), .msb_in(pmsb),
    .phase_in(pph), .load_in(pload), .gen_in(pgen), .tx_in(ptx),
    .pulses_in(npulse), .sin_out(psin), .clk_out(pclk), .rx_out(prx)
  );
  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task close_out;
  begin
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // 1 MHz timer clock
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    osc_edge <= (cyc % 4 == 0);
    tmr_uf <= (cyc % 20 == 0);
    if (cyc == 40000)
    begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  task chk(input string nm, input [31:0] exp, input [31:0] got);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  task apb(input w, input [17:0] a, input [31:0] d);
    integer n;
  begin
    n = 0;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    @(posedge clk_sys);
    while (pready !== 1'h1 && n < 20)
    begin
      @(posedge clk_sys);
      n = n + 1;
    end
    if (n == 20) chk("pready", 32'h1, 32'h0);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  end
  endtask
  task rd(input [17:0] a, input [31:0] exp, input string nm);
  begin
    apb(1'h0, a, 32'h0);
    chk(nm, exp, q);
  end
  endtask
  task prep(input [7:0] rx, input od, input ph);
  begin
    ptx <= rx;
    pmsb <= od;
    pph <= ph;
    pload <= 1'h1;
    @(posedge clk_sys);
    pload <= 1'h0;
  end
  endtask
  task pulses(input [3:0] k);
  begin
    npulse <= k;
    pgen <= 1'h1;
    @(posedge clk_sys);
    pgen <= 1'h0;
  end
  endtask
  task wait_done;
    integer k;
  begin
    k = 0;
    apb(1'h0, A_EN, 32'h0);
    while (q[1] !== 1'h0 && k < 300)
    begin
      apb(1'h0, A_EN, 32'h0);
      k = k + 1;
    end
    chk("running", 32'h1, q);
  end
  endtask
  task t_reset;
  begin
    rd(A_PUL, 32'h5, "pullup reg");
    rd(A_EN, 32'h0, "entrig reg");
    rd(A_CFG, 32'h0, "config reg");
    rd(A_IRQ, 32'h0, "irq reg");
    apb(1'h0, 18'h0, 32'h0);
    chk("slverr", 32'h1, e);
    apb(1'h1, A_PUL, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk("input pullup", 32'h0, in_pu);
    apb(1'h1, A_PUL, 32'h5);
    apb(1'h1, A_EN, 32'h1);
  end
  endtask
  task t_slave(input [7:0] tx, input [7:0] rx);
  begin
    apb(1'h1, A_IRQ, 32'h2);
    apb(1'h1, A_CFG, 32'h8);
    apb(1'h1, A_LO, tx[3:0]);
    apb(1'h1, A_HI, tx[7:4]);
    prep(rx, 1'h1, 1'h0);
    chk("ready idle", 32'h1, pin[3]);
    chk("clock pullup", 32'h1, clk_pu);
    apb(1'h1, A_EN, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk("ready on", 32'h0, pin[3]);
    pulses(4'h9);
    repeat (45) @(posedge clk_sys);
    chk("ready off", 32'h1, pin[3]);
    wait_done;
    repeat (60) @(posedge clk_sys);
    rd(A_IRQ, 32'h3, "flag");
    chk("irq", 32'h1, irq);
    rd(A_LO, rx[3:0], "rx lo");
    rd(A_HI, rx[7:4], "rx hi");
    chk("tx seen", tx, prx);
    apb(1'h1, A_IRQ, 32'h3);
    apb(1'h1, A_EN, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk("ready rearm", 32'h0, pin[3]);
    rd(A_HI, rx[7:4], "hi hold");
    repeat (3) @(posedge clk_sys);
    chk("ready drop", 32'h1, pin[3]);
    pulses(4'h8);
    wait_done;
    apb(1'h1, A_IRQ, 32'h1);
    apb(1'h1, A_CFG, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk("clock pullup", 32'h0, clk_pu);
    rd(A_PUL, 32'h5, "pullup kept");
  end
  endtask
  task t_master(input [1:0] src, input ph, od, input [7:0] tx, rx);
  begin
    apb(1'h1, A_CFG, {od, ph, src});
    apb(1'h1, A_LO, tx[3:0]);
    apb(1'h1, A_HI, tx[7:4]);
    prep(rx, od, ph);
    apb(1'h1, A_EN, 32'h3);
    rd(A_EN, 32'h3, "running");
    wait_done;
    rd(A_IRQ, 32'h1, "flag");
    chk("irq masked", 32'h0, irq);
    rd(A_LO, rx[3:0], "rx lo");
    rd(A_HI, rx[7:4], "rx hi");
    chk("tx seen", tx, prx);
    chk("clock parked", 32'h1, pin[2]);
    apb(1'h1, A_IRQ, 32'h1);
    rd(A_IRQ, 32'h0, "flag clear");
  end
  endtask
  initial
  begin
    mismatches = 0;
    compares = 0;
    cyc = 0;
    resetn = 1'h0;
    {psel, penable, pwrite, osc_edge, tmr_uf, pmsb, pph, pload, pgen} = 0;
    paddr = 18'h0;
    pwdata = 32'h0;
    ptx = 8'h0;
    npulse = 4'h0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'h1;
    t_reset;
    t_slave(8'h5C, 8'h39);
    t_master(2'h3, 1'h1, 1'h1, 8'hC1, 8'h3A);
    t_master(2'h2, 1'h0, 1'h0, 8'h6B, 8'h94);
    t_master(2'h1, 1'h1, 1'h0, 8'h2E, 8'hD3);
    t_master(2'h3, 1'h0, 1'h1, 8'h17, 8'hE4);
    close_out;
  end
endmodule
